//--- core/dbj_pkg.sv
// ****************************************************************
// Shared constants of the jump address decoder
// ****************************************************************
package dbj_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UCMD = 8'h04;
  localparam logic [7:0] OFS_FREG = 8'h08;
  localparam logic [7:0] OFS_TABLE = 8'h0c;
  localparam logic [7:0] OFS_CSADDR = 8'h10;
  localparam logic [7:0] OFS_NEXT = 8'h14;
  localparam logic [7:0] OFS_SEQ = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ****************************************************************
  // Control and status fields
  // ****************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_XLAT_LSB = 1;
  localparam int ST_MINOR_LSB = 0;
  localparam int ST_HELD_BIT = 3;
  localparam int ST_PEND_BIT = 4;
  localparam int ST_PERR_BIT = 5;
  localparam int ST_EARLY_BIT = 6;
  localparam int ST_STABLE_BIT = 7;

  // ****************************************************************
  // Micro-command layout (vector index = 15 - printed bit number)
  // ****************************************************************
  localparam int UC_OP_MSB = 15;
  localparam int UC_OP_LSB = 10;
  localparam int UC_MODE_BIT = 9;
  localparam int UC_I0_BIT = 8;
  localparam int UC_PAR_BIT = 7;
  localparam int UC_I1_BIT = 0;
  localparam logic [5:0] OP_FUNC_JUMP = 6'h01;
  localparam logic [5:0] OP_FORMAT_JUMP = 6'h02;

  // Opcode-holding register bits F04..F08
  localparam int F04_BIT = 11;
  localparam int F07_BIT = 8;
  localparam int F08_BIT = 7;

  // ****************************************************************
  // Address layout and minor cycles
  // ****************************************************************
  localparam int TGT_W = 12;
  localparam int TBL_W = 10;
  localparam int XLAT_W = 3;
  localparam int PAGE_HI = 13;
  localparam int PAGE_LO = 12;
  localparam logic [11:0] ADDR_LAST = 12'hfff;
  localparam logic [11:0] ADDR_NEXT_LAST = 12'hffe;
  localparam logic [2:0] MINOR_CYCLE_SIX = 3'h6;
  localparam logic [2:0] MINOR_CYCLE_SEVEN = 3'h7;
  localparam logic [15:0] CS_RESET = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 20;
  localparam int MINOR_NS = 100;
  localparam int MINOR_CYC = (MINOR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TBL_STABLE_NS = 200;
  localparam int TBL_STABLE_CYC = (TBL_STABLE_NS + CLK_NS - 1) / CLK_NS;

endpackage

//--- core/dbj_tgt_if.sv
`timescale 1ns/1ns
// ****************************************************************
// Target former connection
// ****************************************************************
interface dbj_tgt_if;
  logic [15:0] ucmd;
  logic [15:0] freg;
  logic [9:0] table_word;
  logic [2:0] xlat;
  logic [11:0] fnj_target;
  logic [11:0] frj_target;
  logic parity_ok;

  modport gen (input ucmd, input freg, input table_word, input xlat,
    output fnj_target, output frj_target, output parity_ok);
  modport user (output ucmd, output freg, output table_word, output xlat,
    input fnj_target, input frj_target, input parity_ok);
endinterface

//--- core/dbj_target_gen.sv
`timescale 1ns/1ns
// ****************************************************************
// Branch target formation for both decode jumps
// ****************************************************************
module dbj_target_gen (
  dbj_tgt_if.gen t
);

  logic mode;
  logic i0;
  logic i1;

  assign mode = t.ucmd[dbj_pkg::UC_MODE_BIT];
  assign i0 = t.ucmd[dbj_pkg::UC_I0_BIT];
  assign i1 = t.ucmd[dbj_pkg::UC_I1_BIT];

  // Function decode target; unused positions forced to zero
  always_comb begin
    t.fnj_target = '0; // [RL13]
    t.fnj_target[11] = i0; // [RL2]
    t.fnj_target[10] = i1;
    if (!mode) begin
      t.fnj_target[5:2] = t.freg[dbj_pkg::F04_BIT:dbj_pkg::F07_BIT]; // [RL3]
    end else begin
      t.fnj_target[3] = t.freg[dbj_pkg::F08_BIT]; // [RL4]
      t.fnj_target[2] = 1'b1;
    end
  end

  // Format decode target: translated bits above table address
  assign t.frj_target = {t.xlat, t.table_word[9:1]}; // [RL7]

  // Odd parity over the whole word, undesignated bits included
  assign t.parity_ok = ^t.ucmd; // [RL12]

endmodule

//--- core/dbj_top.sv
`timescale 1ns/1ns
// Overview of operation
// [RL1] Function jump loads next address, sequence except six/seven
// [RL2] Function target from designators and opcode-holding register
// [RL3] Mode clear: designators, F04..F07, trailing zeros
// [RL4] Mode set: designators, zeros, F08, one, zeros
// [RL5] Format jump loads next address only
// [RL6] Table source stable 200 ns before format jump
// [RL7] Format target: table address plus translated bits
// [RL8] Command held in both holds until major end
// [RL9] Format table transfer only in first minor cycle
// [RL10] Bits 02,03 increment at address xFFF
// [RL11] Also at xFFE outside minor cycles six, seven
// [RL12] Undesignated bits only affect parity
// [RL13] Undefined function target bits are zero
module dbj_top #(
  parameter int MINOR_CYC = dbj_pkg::MINOR_CYC,
  parameter int TBL_STABLE_CYC = dbj_pkg::TBL_STABLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] next_address_register,
  output logic [15:0] sequence_register,
  output logic [2:0] minor_cycle,
  output logic major_end
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic run;
  logic [2:0] xlat;
  logic [15:0] freg;
  logic [9:0] table_word;
  logic [15:0] cs_addr;
  logic [15:0] pend_word;
  logic pend;
  logic [15:0] microword_hold_a;
  logic [15:0] microword_hold_b;
  logic held;
  logic exec_first;
  logic perr;
  logic table_early;
  logic [7:0] table_age;
  logic [7:0] div_cnt;
  logic minor_stb;
  logic table_stable;
  logic wr_en;
  logic acc;
  logic [31:0] next_rdata;
  logic next_err;
  logic [5:0] opcode;

  dbj_tgt_if tif ();

  assign tif.ucmd = microword_hold_a;
  assign tif.freg = freg;
  assign tif.table_word = table_word;
  assign tif.xlat = xlat;

  dbj_target_gen u_gen (
    .t(tif)
  );

  assign acc = psel && penable && !pready;
  assign wr_en = acc && pwrite;
  assign opcode = microword_hold_a[dbj_pkg::UC_OP_MSB:dbj_pkg::UC_OP_LSB];
  assign table_stable = (table_age >= 8'(TBL_STABLE_CYC));

  // Full address with hardware-owned bits 02 and 03
  function automatic logic [15:0] full_addr(input logic [15:0] cs,
      input logic [11:0] tgt, input logic [2:0] m);
    logic inc;
    logic [1:0] page;
    inc = (cs[11:0] == dbj_pkg::ADDR_LAST) || // [RL10]
      ((cs[11:0] == dbj_pkg::ADDR_NEXT_LAST) && (m < dbj_pkg::MINOR_CYCLE_SIX)); // [RL11]
    page = cs[dbj_pkg::PAGE_HI:dbj_pkg::PAGE_LO] + {1'b0, inc};
    return {cs[15:14], page, tgt};
  endfunction

  // ****************************************************************
  // Minor cycle timing
  // ****************************************************************

  // Divider giving one strobe per minor cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      minor_stb <= 1'b0;
    end else if (run && div_cnt == 8'(MINOR_CYC - 1)) begin
      div_cnt <= '0;
      minor_stb <= 1'b1;
    end else begin
      div_cnt <= run ? div_cnt + 8'h01 : 8'h00;
      minor_stb <= 1'b0;
    end
  end

  // Minor cycle counter and major end pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      minor_cycle <= '0;
      major_end <= 1'b0;
    end else begin
      major_end <= minor_stb && (minor_cycle == dbj_pkg::MINOR_CYCLE_SEVEN);
      if (minor_stb) begin
        minor_cycle <= minor_cycle + 3'h1;
      end
    end
  end

  // Age of the table word since its last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_age <= '0;
    end else if (wr_en && paddr == dbj_pkg::OFS_TABLE) begin
      table_age <= '0;
    end else if (!table_stable) begin
      table_age <= table_age + 8'h01;
    end
  end

  // ****************************************************************
  // Command hold and execution
  // ****************************************************************

  // Hold registers loaded once, kept to the end of the major cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      microword_hold_a <= '0;
      microword_hold_b <= '0;
      held <= 1'b0;
      exec_first <= 1'b0;
    end else if (minor_stb) begin
      if (held && minor_cycle == dbj_pkg::MINOR_CYCLE_SEVEN) begin
        held <= 1'b0; // [RL8]
      end else if (!held && pend) begin
        microword_hold_a <= pend_word;
        microword_hold_b <= pend_word;
        held <= 1'b1;
        exec_first <= 1'b1;
      end else if (held) begin
        exec_first <= 1'b0; // [RL9]
      end
    end
  end

  // Next address and sequence registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_address_register <= dbj_pkg::CS_RESET;
      sequence_register <= dbj_pkg::CS_RESET;
    end else if (minor_stb && held && tif.parity_ok) begin
      if (opcode == dbj_pkg::OP_FUNC_JUMP) begin
        next_address_register <= full_addr(cs_addr, tif.fnj_target, minor_cycle); // [RL1]
        if (minor_cycle < dbj_pkg::MINOR_CYCLE_SIX) begin
          sequence_register <= full_addr(cs_addr, tif.fnj_target, minor_cycle); // [RL1]
        end
      end else if (opcode == dbj_pkg::OP_FORMAT_JUMP && exec_first) begin
        next_address_register <= full_addr(cs_addr, tif.frj_target, minor_cycle); // [RL5] [RL9]
      end
    end
  end

  // Control storage address: software set, else follows at the major end of a held command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_addr <= dbj_pkg::CS_RESET;
    end else if (wr_en && paddr == dbj_pkg::OFS_CSADDR) begin
      cs_addr <= pwdata[15:0];
    end else if (minor_stb && held && minor_cycle == dbj_pkg::MINOR_CYCLE_SEVEN) begin
      cs_addr <= next_address_register;
    end
  end

  // Sticky flags; a new event wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr <= 1'b0;
      table_early <= 1'b0;
    end else begin
      if (minor_stb && held && exec_first && !tif.parity_ok) begin
        perr <= 1'b1; // [RL12]
      end else if (wr_en && paddr == dbj_pkg::OFS_STATUS && pwdata[dbj_pkg::ST_PERR_BIT]) begin
        perr <= 1'b0;
      end
      if (minor_stb && held && exec_first && opcode == dbj_pkg::OP_FORMAT_JUMP &&
          !table_stable) begin
        table_early <= 1'b1; // [RL6]
      end else if (wr_en && paddr == dbj_pkg::OFS_STATUS && pwdata[dbj_pkg::ST_EARLY_BIT]) begin
        table_early <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  // Software written registers and the command queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      xlat <= '0;
      freg <= '0;
      table_word <= '0;
      pend <= 1'b0;
      pend_word <= '0;
    end else begin
      if (wr_en && paddr == dbj_pkg::OFS_CTRL) begin
        run <= pwdata[dbj_pkg::CTRL_RUN_BIT];
        xlat <= pwdata[dbj_pkg::CTRL_XLAT_LSB +: dbj_pkg::XLAT_W];
      end
      if (wr_en && paddr == dbj_pkg::OFS_FREG) begin
        freg <= pwdata[15:0];
      end
      if (wr_en && paddr == dbj_pkg::OFS_TABLE) begin
        table_word <= pwdata[dbj_pkg::TBL_W-1:0];
      end
      if (wr_en && paddr == dbj_pkg::OFS_UCMD) begin
        pend <= 1'b1;
        pend_word <= pwdata[15:0];
      end else if (minor_stb && !held && pend) begin
        pend <= 1'b0;
      end
    end
  end

  // Read mux and unmapped decode
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    unique case (paddr)
      dbj_pkg::OFS_CTRL: next_rdata = {28'h0, xlat, run};
      dbj_pkg::OFS_UCMD: next_rdata = {16'h0, microword_hold_b};
      dbj_pkg::OFS_FREG: next_rdata = {16'h0, freg};
      dbj_pkg::OFS_TABLE: next_rdata = {22'h0, table_word};
      dbj_pkg::OFS_CSADDR: next_rdata = {16'h0, cs_addr};
      dbj_pkg::OFS_NEXT: next_rdata = {16'h0, next_address_register};
      dbj_pkg::OFS_SEQ: next_rdata = {16'h0, sequence_register};
      dbj_pkg::OFS_STATUS: next_rdata = {24'h0, table_stable, table_early, perr, pend, held,
        minor_cycle};
      default: next_err = 1'b1;
    endcase
  end

  // One wait state answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc && next_err;
      if (acc && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

endmodule

//--- sim/dbj_top_props.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks of the jump address decoder
// ****************************************************************
module dbj_chk #(
  parameter int MINOR_CYC = 5,
  parameter int TBL_STABLE_CYC = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] next_address_register,
  input wire logic [15:0] sequence_register,
  input wire logic [2:0] minor_cycle,
  input wire logic major_end
);
  // Common clock and reset of all checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answer
  chk_ready_after_take: assert property (psel && penable && !pready |=> pready)
    else $error("no ready");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("long ready");
  chk_err_read_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("bad error read");

  // Jump target copies
  chk_seq_late_quiet: assert property (
    $changed(sequence_register) |-> $past(minor_cycle) < 3'h6) else $error("late seq write");
  chk_seq_next_agree: assert property (
    $changed(sequence_register) |-> next_address_register == sequence_register)
    else $error("copies differ");
  chk_seq_zero_bits: assert property (
    sequence_register[9:6] == 4'h0 && sequence_register[1:0] == 2'h0) else $error("bits set");

  // Major cycle end
  chk_major_end_at7: assert property (
    major_end |-> $past(minor_cycle) == 3'h7 && minor_cycle == 3'h0)
    else $error("stray major end");
  chk_major_end_pulse: assert property (major_end |=> !major_end) else $error("long end");
endmodule

bind dbj_top dbj_chk #(.MINOR_CYC(MINOR_CYC), .TBL_STABLE_CYC(TBL_STABLE_CYC)) i_dbj_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .minor_cycle(minor_cycle),
  .next_address_register(next_address_register), .sequence_register(sequence_register),
  .major_end(major_end));

//--- sim/dbj_apb_host.sv
`timescale 1ns/1ns
// ****************************************************************
// Register bus master on the processor side
// ****************************************************************
module dbj_apb_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Setup cycle, then access held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Testbench of the jump address decoder
// ****************************************************************
module tb;
  localparam int MC = 2;
  localparam int TS = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, major_end;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] nxt, seq;
  logic [2:0] minor;
  int miscompares = 0;
  int comparisons = 0;

  // Clock of 20 ns
  always #10 pclk = ~pclk;

  // Design and bus master
  dbj_top #(.MINOR_CYC(MC), .TBL_STABLE_CYC(TS)) i_dbj_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .next_address_register(nxt),
    .sequence_register(seq), .minor_cycle(minor), .major_end(major_end));
  dbj_apb_host i_dbj_apb_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // Compare one value
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write and read with expected error answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
    logic [31:0] q;
    logic e;
    i_dbj_apb_host.xfer(1'b1, a, d, q, e);
    cmp({31'h0, e}, {31'h0, ee});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic ee = 1'b0);
    logic e;
    i_dbj_apb_host.xfer(1'b0, a, 32'h0, q, e);
    cmp({31'h0, e}, {31'h0, ee});
  endtask

  // Odd parity over the whole micro-command
  function automatic logic [15:0] par(input logic [15:0] c);
    return {c[15:8], ~^{c[15:8], c[6:0]}, c[6:0]};
  endfunction

  // Run the timing for two major cycles, then stop it; optional table swap while held
  task automatic run2(input logic [2:0] x, input logic swap = 1'b0, input logic [9:0] tw = 10'h0);
    wr(dbj_pkg::OFS_CTRL, {28'h0, x, 1'b1});
    if (swap) begin
      repeat (2 * MC) @(posedge pclk);
      wr(dbj_pkg::OFS_TABLE, {22'h0, tw});
    end
    repeat (2) begin
      @(posedge pclk);
      while (major_end !== 1'b1) @(posedge pclk);
    end
    wr(dbj_pkg::OFS_CTRL, {28'h0, x, 1'b0});
  endtask

  // Reset values and unmapped places
  task automatic t_reset;
    logic [31:0] q;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), q);
      cmp(q, 32'h0);
    end
    rd(8'h20, q, 1'b1);
    cmp(q, 32'h0);
    wr(8'h24, 32'hffff, 1'b1);
  endtask

  // Function jump: both copies, page carry near the end of a page
  task automatic t_fnj(input logic m, input logic i0, input logic i1, input logic [15:0] cs,
    input logic [15:0] f, input logic [5:0] junk);
    logic [31:0] q;
    logic [11:0] t;
    logic [1:0] pn, ps;
    t = m ? {i0, i1, 6'h00, f[7], 1'b1, 2'h0} : {i0, i1, 4'h0, f[11:8], 2'h0};
    pn = cs[13:12] + {1'b0, cs[11:0] == 12'hfff};
    ps = cs[13:12] + {1'b0, cs[11:1] == 11'h7ff};
    wr(dbj_pkg::OFS_CSADDR, {16'h0, cs});
    wr(dbj_pkg::OFS_FREG, {16'h0, f});
    wr(dbj_pkg::OFS_UCMD, {16'h0, par({dbj_pkg::OP_FUNC_JUMP, m, i0, 1'b0, junk, i1})});
    run2(3'h0);
    rd(dbj_pkg::OFS_NEXT, q);
    cmp(q, {16'h0, cs[15:14], pn, t});
    cmp({16'h0, nxt}, {16'h0, cs[15:14], pn, t});
    rd(dbj_pkg::OFS_SEQ, q);
    cmp(q, {16'h0, cs[15:14], ps, t});
    cmp({16'h0, seq}, {16'h0, cs[15:14], ps, t});
  endtask

  // Format jump: table word with translated bits, sequence copy untouched
  task automatic t_frj(input logic [9:0] tw, input logic [2:0] x);
    logic [31:0] q, s;
    logic [15:0] c;
    c = par({dbj_pkg::OP_FORMAT_JUMP, 10'h0});
    wr(dbj_pkg::OFS_CSADDR, 32'h3fff);
    wr(dbj_pkg::OFS_CTRL, {28'h0, x, 1'b0});
    wr(dbj_pkg::OFS_TABLE, {22'h0, tw});
    repeat (TS + 1) @(posedge pclk);
    rd(dbj_pkg::OFS_SEQ, s);
    wr(dbj_pkg::OFS_UCMD, {16'h0, c});
    run2(x, 1'b1, ~tw);
    rd(dbj_pkg::OFS_NEXT, q);
    cmp(q, {20'h0, x, tw[9:1]});
    rd(dbj_pkg::OFS_SEQ, q);
    cmp(q, s);
    rd(dbj_pkg::OFS_UCMD, q);
    cmp(q, {16'h0, c});
    rd(dbj_pkg::OFS_STATUS, q);
    cmp({30'h0, q[dbj_pkg::ST_STABLE_BIT], q[dbj_pkg::ST_EARLY_BIT]}, 32'h2);
  endtask

  // Bad parity: nothing moves, error flag set, then cleared by a one
  task automatic t_parity;
    logic [31:0] q, n;
    rd(dbj_pkg::OFS_NEXT, n);
    wr(dbj_pkg::OFS_UCMD, {16'h0, par({dbj_pkg::OP_FUNC_JUMP, 10'h301}) ^ 16'h0080});
    run2(3'h0);
    rd(dbj_pkg::OFS_NEXT, q);
    cmp(q, n);
    rd(dbj_pkg::OFS_STATUS, q);
    cmp({31'h0, q[dbj_pkg::ST_PERR_BIT]}, 32'h1);
    cmp({29'h0, minor}, {29'h0, q[dbj_pkg::ST_MINOR_LSB +: 3]});
    wr(dbj_pkg::OFS_STATUS, 32'h1 << dbj_pkg::ST_PERR_BIT);
    rd(dbj_pkg::OFS_STATUS, q);
    cmp({31'h0, q[dbj_pkg::ST_PERR_BIT]}, 32'h0);
  endtask

  // Verdict
  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fnj(1'b0, 1'b1, 1'b0, 16'h0fff, 16'h0a00, 6'h00);
    t_fnj(1'b1, 1'b0, 1'b1, 16'h2ffe, 16'h0080, 6'h3f);
    t_fnj(1'b0, 1'b1, 1'b1, 16'h1234, 16'hf5ff, 6'h2a);
    t_frj(10'h2a5, 3'h5);
    t_parity();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("[FAIL] %0t timeout", $time);
    stop_test();
  end
endmodule
